// ===== hdl/msic_pkg.sv
// Shared constants and types for the multi-source interrupt controller
package msic_pkg;

    localparam int NUM_CHAN = 6;
    localparam int NUM_PINS = 19;
    localparam int NUM_SRC_TYPES = 7;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 32;

    // Register byte offsets; per-channel registers step by one word
    localparam logic [7:0] SELECT_BASE = 8'h00;
    localparam logic [7:0] MASK_BASE = 8'h20;
    localparam logic [7:0] STATUS_BASE = 8'h40;
    localparam logic [7:0] CAPTURE_EN_OFFSET = 8'h60;
    localparam logic [7:0] PENDING_OFFSET = 8'h64;
    localparam logic [7:0] LATCH_BASE = 8'h80;
    localparam logic [7:0] CHAN_STRIDE = 8'h04;

    // Source-select field positions (one bit per source type)
    localparam int SEL_DIN_PAIR = 0;
    localparam int SEL_DIN_HIGH = 1;
    localparam int SEL_DIN_LOW = 2;
    localparam int SEL_INDEX = 3;
    localparam int SEL_MATCH = 4;
    localparam int SEL_TIMER = 5;
    localparam int SEL_ANALOG = 6;

    // Status / mask field positions
    localparam int STS_DIN_EVEN = 0;
    localparam int STS_DIN_ODD = 1;
    localparam int STS_DIN_HIGH = 2;
    localparam int STS_DIN_LOW = 3;
    localparam int STS_INDEX = 4;
    localparam int STS_MATCH = 5;
    localparam int STS_TIMER = 6;
    localparam int STS_ANALOG = 7;

    // Pin numbering of the isolated inputs
    localparam int PIN_PAIR_FIRST = 6;
    localparam int PIN_HIGH = 18;
    localparam int PIN_LOW_FIRST = 0;

    // Reset values
    localparam logic [6:0] SELECT_RESET = 7'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [5:0] CAPTURE_EN_RESET = 6'h00;
    localparam logic [31:0] LATCH_RESET = 32'h0000_0000;

    // One channel's events, laid out exactly as its status word
    typedef struct packed {
        logic analog;
        logic timer;
        logic match;
        logic index;
        logic din_low;
        logic din_high;
        logic din_odd;
        logic din_even;
    } chan_events_type;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

endpackage : msic_pkg

// ===== hdl/multi_source_interrupt_control.sv
// Per-channel interrupt source selection, sticky status and host request
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Operation
// [R1] Up to seven source types can raise the host request, each enabled on its own per channel.
// [R2] Source types 0, 1 and 2 come from the isolated digital input pins.
// [R3] Type 0 gives channel n the input pair 6+2n and 7+2n, both enabled together.
// [R4] With type 0 enabled, a trigger on either input of the pair raises the interrupt.
// [R5] Each of the six channels has its own source-select setting covering only its column.
// [R6] Type 3 triggers on the channel's index input, type 4 on its position match.
// [R7] Type 5 is the internal timer on channel 0 only; type 6 is the analog match.
// [R8] Each channel has a readable 8-bit status with bit 6 timer and bit 7 analog.
// [R9] Status bit 0 reports the even pin of the channel's input pair.
// [R10] Status bit 1 reports the odd pin of the channel's input pair.
// [R11] Status bit 2 reports input pin 18, the type 1 source.
// [R12] Status bit 3 reports the channel's type 2 input, one of pins 0 to 5.
// [R13] Status bit 4 reports an index event and bit 5 a position match event.
// [R14] A rising index edge raises the event and, with capture on, latches the count.
// [R15] A match event is raised as soon as the counter reaches its compare value.
// [R16] Status bits stay set until cleared and the request is high while any is set; here only bits left on in the channel's mask raise it.
// [R17] The host reads a channel's status after each interrupt and clears it.
module multi_source_interrupt_control (
    input wire logic i_sys_clk, // 125 MHz card clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic [7:0] i_addr, // Register byte address
    input wire logic [31:0] i_wdata, // Register write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [31:0] o_rdata, // Read data, cycle after i_rd
    input wire logic [18:0] i_isolated_input_pin, // Isolated input pins
    input wire logic [5:0] i_encoder_index_input, // Index pins per channel
    input wire logic [5:0] i_position_match_flag, // Compare-true per channel
    input wire logic i_timer_tick, // Internal timer event
    input wire logic [5:0] i_analog_match, // Analog compare-true
    input wire logic [5:0][31:0] i_encoder_count, // Live counter values
    output logic o_irq // Level request to the host
);

    localparam int NPIN_ALL = msic_pkg::NUM_PINS + msic_pkg::NUM_CHAN;

    msic_pkg::bus_req_type bus;
    logic [NPIN_ALL-1:0] pin_s1_reg;
    logic [NPIN_ALL-1:0] pin_s2_reg;
    logic [NPIN_ALL-1:0] pin_s3_reg;
    logic [NPIN_ALL-1:0] pin_lvl_reg;
    logic [NPIN_ALL-1:0] pin_lvl_d_reg;
    logic [NPIN_ALL-1:0] pin_rise;
    logic [18:0] din_rise;
    logic [5:0] index_rise;
    logic [5:0] match_d_reg;
    logic [5:0] analog_d_reg;
    logic timer_d_reg;
    logic [6:0] select_reg [msic_pkg::NUM_CHAN];
    logic [7:0] mask_reg [msic_pkg::NUM_CHAN];
    logic [7:0] status_reg [msic_pkg::NUM_CHAN];
    logic [7:0] status_next [msic_pkg::NUM_CHAN];
    logic [31:0] latch_reg [msic_pkg::NUM_CHAN];
    msic_pkg::chan_events_type events [msic_pkg::NUM_CHAN];
    logic [5:0] capture_en_reg;
    logic [5:0] pending;
    logic [31:0] rdata_next;
    logic irq_next;

    // True when addr hits the per-channel word of the given bank
    function automatic logic hits_chan(input logic [7:0] addr,
                                       input logic [7:0] base,
                                       input int ch);
        logic [7:0] target;
        target = base + 8'(ch * 4);
        return addr == target;
    endfunction : hits_chan

    // Rising edge of a level against its delayed copy
    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rise

    assign bus.addr = i_addr;
    assign bus.wdata = i_wdata;
    assign bus.wr = i_wr;
    assign bus.rd = i_rd;

    // Pin inputs cross into the clock domain; a level is accepted only once
    // the second and third stages agree, which also rejects one-cycle glitches
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            pin_s1_reg <= {i_encoder_index_input, i_isolated_input_pin};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_lvl_reg <= '0;
            pin_lvl_d_reg <= '0;
        end else begin
            for (int i = 0; i < NPIN_ALL; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_lvl_reg[i] <= pin_s3_reg[i];
                end
            end
            pin_lvl_d_reg <= pin_lvl_reg;
        end
    end

    assign pin_rise = pin_lvl_reg & ~pin_lvl_d_reg;
    assign din_rise = pin_rise[18:0];
    assign index_rise = pin_rise[NPIN_ALL-1:19]; // [R14]

    // Same-clock sources need only an edge detector
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            match_d_reg <= '0;
            analog_d_reg <= '0;
            timer_d_reg <= 1'b0;
        end else begin
            match_d_reg <= i_position_match_flag;
            analog_d_reg <= i_analog_match;
            timer_d_reg <= i_timer_tick;
        end
    end

    // Event gating by each channel's own source select
    always_comb begin
        for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
            events[ch] = '0;
            events[ch].din_even = select_reg[ch][msic_pkg::SEL_DIN_PAIR] &
                din_rise[msic_pkg::PIN_PAIR_FIRST + 2 * ch]; // [R3] [R4] [R9]
            events[ch].din_odd = select_reg[ch][msic_pkg::SEL_DIN_PAIR] &
                din_rise[msic_pkg::PIN_PAIR_FIRST + 2 * ch + 1]; // [R4] [R10]
            events[ch].din_low = select_reg[ch][msic_pkg::SEL_DIN_LOW] &
                din_rise[msic_pkg::PIN_LOW_FIRST + ch]; // [R2] [R12]
            events[ch].index = select_reg[ch][msic_pkg::SEL_INDEX] &
                index_rise[ch]; // [R6] [R13]
            events[ch].match = select_reg[ch][msic_pkg::SEL_MATCH] &
                rise(i_position_match_flag[ch], match_d_reg[ch]); // [R15]
            events[ch].analog = select_reg[ch][msic_pkg::SEL_ANALOG] &
                rise(i_analog_match[ch], analog_d_reg[ch]); // [R7] [R8]
            if (ch == 0) begin
                events[ch].din_high = select_reg[ch][msic_pkg::SEL_DIN_HIGH] &
                    din_rise[msic_pkg::PIN_HIGH]; // [R11]
                events[ch].timer = select_reg[ch][msic_pkg::SEL_TIMER] &
                    rise(i_timer_tick, timer_d_reg); // [R7] [R8]
            end
        end
    end

    // Source select and mask, one word per channel
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
                select_reg[ch] <= msic_pkg::SELECT_RESET;
                mask_reg[ch] <= msic_pkg::MASK_RESET;
            end
        end else if (bus.wr) begin
            for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
                if (hits_chan(bus.addr, msic_pkg::SELECT_BASE, ch)) begin
                    select_reg[ch] <= bus.wdata[6:0]; // [R1] [R5]
                end
                if (hits_chan(bus.addr, msic_pkg::MASK_BASE, ch)) begin
                    mask_reg[ch] <= bus.wdata[7:0];
                end
            end
        end
    end

    // Sticky status; a new event in the clearing cycle survives the clear
    always_comb begin
        for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
            status_next[ch] = status_reg[ch];
            if (bus.wr && hits_chan(bus.addr, msic_pkg::STATUS_BASE, ch)) begin
                status_next[ch] = status_reg[ch] & ~bus.wdata[7:0];
            end
            status_next[ch] = status_next[ch] | events[ch]; // [R16]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
                status_reg[ch] <= msic_pkg::STATUS_RESET;
            end
        end else begin
            for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
                status_reg[ch] <= status_next[ch];
            end
        end
    end

    // Index capture of the live count
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            capture_en_reg <= msic_pkg::CAPTURE_EN_RESET;
        end else if (bus.wr && bus.addr == msic_pkg::CAPTURE_EN_OFFSET) begin
            capture_en_reg <= bus.wdata[5:0];
        end
    end

    // Capture follows the index edge even when the index interrupt is off
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
                latch_reg[ch] <= msic_pkg::LATCH_RESET;
            end
        end else begin
            for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
                if (index_rise[ch] && capture_en_reg[ch]) begin
                    latch_reg[ch] <= i_encoder_count[ch]; // [R14]
                end
            end
        end
    end

    // Request level; computed from the next status so it tracks it exactly
    always_comb begin
        irq_next = 1'b0;
        for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
            pending[ch] = |(status_reg[ch] & mask_reg[ch]);
            if (|(status_next[ch] & mask_reg[ch])) begin
                irq_next = 1'b1; // [R16]
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_next; // [R1]
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = '0;
        if (bus.addr == msic_pkg::CAPTURE_EN_OFFSET) begin
            rdata_next = {26'h0, capture_en_reg};
        end
        if (bus.addr == msic_pkg::PENDING_OFFSET) begin
            rdata_next = {26'h0, pending};
        end
        for (int ch = 0; ch < msic_pkg::NUM_CHAN; ch++) begin
            if (hits_chan(bus.addr, msic_pkg::SELECT_BASE, ch)) begin
                rdata_next = {25'h0, select_reg[ch]};
            end
            if (hits_chan(bus.addr, msic_pkg::MASK_BASE, ch)) begin
                rdata_next = {24'h0, mask_reg[ch]};
            end
            if (hits_chan(bus.addr, msic_pkg::STATUS_BASE, ch)) begin
                rdata_next = {24'h0, status_reg[ch]}; // [R8] [R17]
            end
            if (hits_chan(bus.addr, msic_pkg::LATCH_BASE, ch)) begin
                rdata_next = latch_reg[ch];
            end
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule : multi_source_interrupt_control

// ===== tb/msic_monitor.sv
// Port checker for the interrupt controller
`timescale 1ns/1ps
module msic_monitor (
    input wire logic i_sys_clk, // Clock
    input wire logic i_rst_b, // Reset
    input wire logic [7:0] i_addr, // Address
    input wire logic [31:0] i_wdata, // Data
    input wire logic i_wr, // Write
    input wire logic i_rd, // Read
    input wire logic [31:0] o_rdata, // Read data
    input wire logic [18:0] i_isolated_input_pin, // Pins
    input wire logic [5:0] i_position_match_flag, // Match
    input wire logic i_timer_tick, // Timer
    input wire logic [5:0] i_analog_match, // Analog
    input wire logic o_irq // Request
);
    logic [6:0] sel_reg [6];
    logic [7:0] msk_reg [6];
    logic [18:0] pin_q;
    logic [5:0] ana_q;
    logic [5:0] mat_q;
    logic pin_hit;
    logic ana_hit;
    logic mat_hit;
    logic sel_a;
    logic msk_a;
    assign sel_a = i_addr < 8'h18 && i_addr[1:0] == 2'h0;
    assign msk_a = i_addr >= 8'h20 && i_addr < 8'h38 && i_addr[1:0] == 2'h0;
    // Shadow select and mask so only events that may raise a request count
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_reg <= '{default: 7'h00};
            msk_reg <= '{default: 8'hff};
            pin_q <= 19'h00000;
            ana_q <= 6'h00;
            mat_q <= 6'h00;
        end else begin
            pin_q <= i_isolated_input_pin;
            ana_q <= i_analog_match;
            mat_q <= i_position_match_flag;
            if (i_wr && sel_a)
                sel_reg[i_addr[4:2]] <= i_wdata[6:0];
            if (i_wr && msk_a)
                msk_reg[i_addr[4:2]] <= i_wdata[7:0];
        end
    end
    always_comb begin
        pin_hit = 1'b0;
        ana_hit = 1'b0;
        mat_hit = 1'b0;
        for (int c = 0; c < 6; c++) begin
            pin_hit |= sel_reg[c][0] & ((i_isolated_input_pin[6+2*c]
                & ~pin_q[6+2*c] & msk_reg[c][0]) | (msk_reg[c][1]
                & i_isolated_input_pin[7+2*c] & ~pin_q[7+2*c]));
            ana_hit |= i_analog_match[c] & ~ana_q[c] & sel_reg[c][6]
                & msk_reg[c][7];
            mat_hit |= i_position_match_flag[c] & ~mat_q[c]
                & sel_reg[c][4] & msk_reg[c][5];
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside a read cycle");
    AST_SEL_RD: assert property (i_rd && sel_a |=>
        o_rdata == {25'h0, $past(sel_reg[i_addr[4:2]])})
        else $error("select readback wrong");
    AST_MSK_RD: assert property (i_rd && msk_a |=>
        o_rdata == {24'h0, $past(msk_reg[i_addr[4:2]])})
        else $error("mask readback wrong");
    AST_UNMAPPED: assert property (i_rd && i_addr >= 8'h98 |=>
        o_rdata == 32'h0) else $error("unmapped read not zero");
    AST_STS_WIDTH: assert property (i_rd && i_addr[7:5] == 3'h2 |=>
        o_rdata[31:8] == 24'h0) else $error("status upper bits set");
    AST_ANALOG: assert property (ana_hit && !i_wr |=> o_irq)
        else $error("analog event gave no request");
    AST_MATCH: assert property (mat_hit && !i_wr |=> o_irq)
        else $error("match event gave no request");
    AST_TIMER: assert property ($rose(i_timer_tick) && sel_reg[0][5]
        && msk_reg[0][6] && !i_wr |=> o_irq)
        else $error("timer event gave no request");
    AST_PIN_PAIR: assert property (pin_hit |-> ##[2:8] o_irq)
        else $error("pair pin event gave no request");
    AST_IRQ_HOLD: assert property (o_irq && !i_wr |=> o_irq)
        else $error("request dropped without a write");
endmodule : msic_monitor
bind multi_source_interrupt_control msic_monitor i_mon (
    .i_sys_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_isolated_input_pin, .i_position_match_flag, .i_timer_tick,
    .i_analog_match, .o_irq
);

// ===== tb/host_bus_model.sv
// Host model: register bus master and interrupt service routine
`timescale 1ns/1ps
module host_bus_model (
    input wire logic i_sys_clk, // Clock
    input wire logic [31:0] i_rdata, // Read data
    input wire logic i_irq, // Request
    output logic [7:0] o_addr, // Address
    output logic [31:0] o_wdata, // Data
    output logic o_wr, // Write
    output logic o_rd // Read
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Released lines flip so stale values are never mistaken for data
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_sys_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        // Data stand only in this cycle; take them mid-cycle, clear of edges
        @(negedge i_sys_clk);
        d = i_rdata;
    endtask : rd
    task automatic service(input int ch, output logic [7:0] st,
                           output bit seen);
        logic [31:0] d;
        seen = 1'b0;
        for (int n = 0; n < 20 && !seen; n++) begin
            @(posedge i_sys_clk);
            seen = (i_irq === 1'b1);
        end
        rd(8'h40 + 8'(4 * ch), d);
        st = d[7:0];
        wr(8'h40 + 8'(4 * ch), {24'h0, st});
    endtask : service
endmodule : host_bus_model

// ===== tb/tb_multi_source_interrupt_control.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_multi_source_interrupt_control;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic irq;
    logic [18:0] pins = 19'h00000;
    logic [5:0] idx_in = 6'h00;
    logic [5:0] mat = 6'h00;
    logic tim = 1'b0;
    logic [5:0] ana = 6'h00;
    logic [5:0][31:0] cnt;
    int num_errors = 0;
    int compares = 0;
    always #4 clk = ~clk;
    initial for (int c = 0; c < 6; c++) cnt[c] = 32'h1234_0000 + 32'(c);
    multi_source_interrupt_control i_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_isolated_input_pin(pins),
        .i_encoder_index_input(idx_in), .i_position_match_flag(mat),
        .i_timer_tick(tim), .i_analog_match(ana), .i_encoder_count(cnt),
        .o_irq(irq));
    host_bus_model i_host (.i_sys_clk(clk), .i_rdata(rdata), .i_irq(irq),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic drive(input int src, input int i, input logic v);
        @(posedge clk);
        case (src)
            0: pins[i] <= v;
            1: idx_in[i] <= v;
            2: mat[i] <= v;
            3: tim <= v;
            default: ana[i] <= v;
        endcase
    endtask : drive
    // One enabled event, serviced by the host, then the source disabled
    task automatic ev(input int ch, input int sb, input int src,
                      input int i, input logic [7:0] e);
        logic [7:0] st;
        logic [31:0] d;
        bit seen;
        i_host.wr(8'(4 * ch), 32'h1 << sb);
        drive(src, i, 1'b1);
        i_host.service(ch, st, seen);
        check("irq", {31'h0, seen}, 32'h1);
        check("status", {24'h0, st}, {24'h0, e});
        #1 check("irq clear", {31'h0, irq}, 32'h0);
        drive(src, i, 1'b0);
        i_host.rd(8'h40 + 8'(4 * ch), d);
        check("status clear", d, 32'h0);
        i_host.wr(8'(4 * ch), 32'h0);
    endtask : ev
    task automatic t_reset();
        logic [31:0] d;
        i_host.rd(8'h00, d);
        check("select", d, 32'h0);
        i_host.rd(8'h20, d);
        check("mask", d, 32'hff);
        i_host.rd(8'hfc, d);
        check("unmapped", d, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pins();
        for (int c = 0; c < 6; c++) begin
            ev(c, 0, 0, 6 + 2 * c, 8'h01);
            ev(c, 0, 0, 7 + 2 * c, 8'h02);
            ev(c, 2, 0, c, 8'h08);
        end
        ev(0, 1, 0, 18, 8'h04);
        $display("test pins done");
    endtask : t_pins
    task automatic t_encoder();
        logic [31:0] d;
        i_host.wr(8'h60, 32'h3f);
        for (int c = 0; c < 6; c++) begin
            ev(c, 3, 1, c, 8'h10);
            i_host.rd(8'h80 + 8'(4 * c), d);
            check("latch", d, cnt[c]);
            ev(c, 4, 2, c, 8'h20);
        end
        $display("test encoder done");
    endtask : t_encoder
    task automatic t_timer_analog();
        ev(0, 5, 3, 0, 8'h40);
        for (int c = 0; c < 6; c++) ev(c, 6, 4, c, 8'h80);
        $display("test timer analog done");
    endtask : t_timer_analog
    task automatic t_gate();
        logic [31:0] d;
        logic [7:0] st;
        bit seen;
        i_host.wr(8'h04, 32'h40);
        drive(4, 2, 1'b1);
        repeat (4) @(posedge clk);
        check("other column", {31'h0, irq}, 32'h0);
        i_host.rd(8'h48, d);
        check("dropped", d, 32'h0);
        drive(4, 2, 1'b0);
        i_host.wr(8'h04, 32'h0);
        i_host.wr(8'h28, 32'h7f);
        i_host.wr(8'h08, 32'h40);
        drive(4, 2, 1'b1);
        repeat (4) @(posedge clk);
        check("masked", {31'h0, irq}, 32'h0);
        i_host.rd(8'h48, d);
        check("masked status", d, 32'h80);
        i_host.rd(8'h64, d);
        check("pending masked", d, 32'h0);
        i_host.wr(8'h28, 32'hff);
        i_host.rd(8'h64, d);
        check("pending", d, 32'h4);
        i_host.service(2, st, seen);
        check("unmasked", {31'h0, seen}, 32'h1);
        drive(4, 2, 1'b0);
        i_host.wr(8'h08, 32'h0);
        $display("test gate done");
    endtask : t_gate
    task automatic results();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_pins();
        t_encoder();
        t_timer_analog();
        t_gate();
        results();
    end
    // About 700 cycles are expected; far longer means a hang
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule : tb_multi_source_interrupt_control
